// file: core/dmsr_defines.svh
// register offsets, field positions and reset values of the drive monitor bank
`ifndef DMSR_DEFINES_SVH
`define DMSR_DEFINES_SVH
`define DMSR_ADDR_INPUT_IMAGE   16'h002B
`define DMSR_ADDR_CONDITION     16'h002C
`define DMSR_ADDR_OUTPUT_IMAGE  16'h002D
`define DMSR_ADDR_DC_LINK       16'h0031
`define DMSR_ADDR_FEEDBACK      16'h0038
`define DMSR_ADDR_SIGNED_A      16'h0039
`define DMSR_ADDR_SIGNED_B      16'h003A
`define DMSR_ADDR_MAIN_FW       16'h003B
`define DMSR_ADDR_FLASH_FW      16'h003C
`define DMSR_ADDR_LINK_ERR      16'h003D
`define DMSR_ADDR_POWER_RATING  16'h003E
`define DMSR_ADDR_CTRL_METHOD   16'h003F
`define DMSR_NUM_INPUTS         7
`define DMSR_NUM_OUTPUTS        2
`define DMSR_COND_RUNNING       0
`define DMSR_COND_ZERO_SPEED    1
`define DMSR_COND_FREQ_AGREE    2
`define DMSR_COND_DESIRED_AGREE 3
`define DMSR_COND_FREQ_LOW      4
`define DMSR_COND_FREQ_HIGH     5
`define DMSR_COND_STARTUP_DONE  6
`define DMSR_COND_LOW_VOLTAGE   7
`define DMSR_COND_BASEBLOCK     8
`define DMSR_COND_REF_SOURCE    9
`define DMSR_COND_RUN_SOURCE    10
`define DMSR_COND_OVERTORQUE    11
`define DMSR_COND_RETRYING      13
`define DMSR_COND_ANY_ERROR     14
`define DMSR_COND_TIMEOUT       15
`define DMSR_ERR_CRC            0
`define DMSR_ERR_LENGTH         1
`define DMSR_ERR_PARITY         3
`define DMSR_ERR_OVERRUN        4
`define DMSR_ERR_FRAMING        5
`define DMSR_ERR_TIMEOUT        6
`define DMSR_ERR_MASK           16'h007B
`define DMSR_WORD_RESET         16'h0000
`endif

// file: core/dmsr_pkg.sv
// types shared by the drive monitor bank
package dmsr_pkg;
	typedef logic [15:0] dmsr_word_t;
	typedef enum logic [1:0] {
		DMSR_ACC_OK,
		DMSR_ACC_BAD_ADDR,
		DMSR_ACC_READ_ONLY
	} dmsr_acc_t;
endpackage

// file: core/dmsr_monitor_bank.sv
// read-only monitor register bank of the drive with latched link errors
//
// Contract
// - bit0 and bit1 of input image show input_terminal_1 and input_terminal_2 live.
// - input image bits 2..6 mirror input_terminal_3..7; bits 7..15 unused.
// - condition bit0 is running, bit1 is zero speed.
// - condition bit2 reference agree, bit3 desired frequency agree.
// - condition bit5 set when output frequency >= detection_level_setting.
// - condition bit6 reads 1 once startup sequence has completed.
// - condition bit8 reads 1 while output is in baseblock.
// - bit10 run source, bit9 reference source; 0 means communication link.
// - condition bit14 set on any error, link time-out included.
// - condition bit15 set when a link time-out has been detected.
// - output image bit0 output_contact_1, bit1 output_contact_2; rest unused.
// - feedback level unsigned, 10 counts per percent of maximum frequency.
// - two signed monitors in two's complement, 10 counts per percent.
// - link error register latches crc, length, parity, overrun, framing, time-out.
// - error reset clears latched link errors even while running.
// - monitor registers are read-only; writes are rejected.
`timescale 1ns/1ps
`include "dmsr_defines.svh"
module dmsr_monitor_bank (
	input wire logic ref_clk_i, // controller clock, 200 MHz
	input wire logic reset_n_i, // asynchronous reset, active low
	input wire logic [`DMSR_NUM_INPUTS-1:0] input_terminal_i, // terminal pins 1..7, async
	input wire logic [`DMSR_NUM_OUTPUTS-1:0] output_contact_i, // contact states 1..2
	input wire logic running_i, // drive operating
	input wire logic zero_speed_i, // output at zero speed
	input wire logic freq_agree_i, // output matches reference
	input wire logic desired_agree_i, // output matches desired frequency
	input wire logic [15:0] output_freq_i, // output frequency
	input wire logic [15:0] detection_level_setting_i, // frequency detection level
	input wire logic startup_done_i, // startup sequence completed
	input wire logic low_voltage_i, // undervoltage detected
	input wire logic baseblock_i, // output stage inhibited
	input wire logic ref_from_link_i, // frequency reference from link
	input wire logic run_from_link_i, // run command from link
	input wire logic overtorque_i, // overtorque detected
	input wire logic retrying_i, // fault retry in progress
	input wire logic drive_fault_i, // any drive fault other than link errors
	input wire logic crc_err_i, // crc error pulse
	input wire logic length_err_i, // bad length pulse
	input wire logic parity_err_i, // parity error pulse
	input wire logic overrun_err_i, // overrun error pulse
	input wire logic framing_err_i, // framing error pulse
	input wire logic timeout_err_i, // link time-out pulse
	input wire logic error_reset_i, // error reset pulse
	input wire dmsr_pkg::dmsr_word_t dc_link_voltage_i, // measured dc link voltage
	input wire dmsr_pkg::dmsr_word_t feedback_level_i, // unsigned feedback, 10/1%
	input wire dmsr_pkg::dmsr_word_t signed_monitor_a_i, // signed monitor, 10/1%
	input wire dmsr_pkg::dmsr_word_t signed_monitor_b_i, // signed monitor, 10/1%
	input wire dmsr_pkg::dmsr_word_t main_firmware_version_i, // main firmware number
	input wire dmsr_pkg::dmsr_word_t flash_firmware_version_i, // flash firmware number
	input wire dmsr_pkg::dmsr_word_t power_rating_setting_i, // power rating setting
	input wire dmsr_pkg::dmsr_word_t control_method_code_i, // control method code
	input wire logic req_valid_i, // access request strobe
	input wire logic req_write_i, // 1 write, 0 read
	input wire dmsr_pkg::dmsr_word_t req_addr_i, // register number
	output logic rsp_valid_o, // answer strobe, one cycle
	output dmsr_pkg::dmsr_word_t rsp_data_o, // read data
	output dmsr_pkg::dmsr_acc_t rsp_status_o // access result
);
	import dmsr_pkg::*;

	logic [`DMSR_NUM_INPUTS-1:0] in_meta_r;
	logic [`DMSR_NUM_INPUTS-1:0] in_sync_r;
	dmsr_word_t input_image_r;
	dmsr_word_t condition_r;
	dmsr_word_t output_image_r;
	dmsr_word_t link_err_r;
	dmsr_word_t link_err_nxt;
	dmsr_word_t cond_nxt;
	dmsr_word_t rd_word;
	dmsr_acc_t rd_status;
	logic addr_hit;

	// terminals are asynchronous pins: two stages before any logic sees them
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			in_meta_r <= '0;
			in_sync_r <= '0;
		end else begin
			in_meta_r <= input_terminal_i;
			in_sync_r <= in_meta_r;
		end
	end

	// terminal images refresh every cycle, unused bits stay zero
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			input_image_r <= `DMSR_WORD_RESET;
			output_image_r <= `DMSR_WORD_RESET;
		end else begin
			input_image_r <= {9'h0_00, in_sync_r};
			output_image_r <= {14'h0_000, output_contact_i};
		end
	end

	// condition flags assembled from live drive status and the link error latch
	always_comb begin
		cond_nxt = `DMSR_WORD_RESET;
		cond_nxt[`DMSR_COND_RUNNING] = running_i;
		cond_nxt[`DMSR_COND_ZERO_SPEED] = zero_speed_i;
		cond_nxt[`DMSR_COND_FREQ_AGREE] = freq_agree_i;
		cond_nxt[`DMSR_COND_DESIRED_AGREE] = desired_agree_i;
		cond_nxt[`DMSR_COND_FREQ_LOW] = (output_freq_i <= detection_level_setting_i);
		cond_nxt[`DMSR_COND_FREQ_HIGH] = (output_freq_i >= detection_level_setting_i);
		cond_nxt[`DMSR_COND_STARTUP_DONE] = startup_done_i;
		cond_nxt[`DMSR_COND_LOW_VOLTAGE] = low_voltage_i;
		cond_nxt[`DMSR_COND_BASEBLOCK] = baseblock_i;
		cond_nxt[`DMSR_COND_REF_SOURCE] = !ref_from_link_i;
		cond_nxt[`DMSR_COND_RUN_SOURCE] = !run_from_link_i;
		cond_nxt[`DMSR_COND_OVERTORQUE] = overtorque_i;
		cond_nxt[`DMSR_COND_RETRYING] = retrying_i;
		// time-out is taken from the latch so the flag stays until error reset
		cond_nxt[`DMSR_COND_TIMEOUT] = link_err_nxt[`DMSR_ERR_TIMEOUT];
		cond_nxt[`DMSR_COND_ANY_ERROR] = drive_fault_i | (|link_err_nxt);
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			condition_r <= `DMSR_WORD_RESET;
		end else begin
			condition_r <= cond_nxt;
		end
	end

	// sticky link errors; a new event in the reset cycle survives the clear
	always_comb begin
		link_err_nxt = error_reset_i ? `DMSR_WORD_RESET : link_err_r;
		link_err_nxt[`DMSR_ERR_CRC] = link_err_nxt[`DMSR_ERR_CRC] | crc_err_i;
		link_err_nxt[`DMSR_ERR_LENGTH] = link_err_nxt[`DMSR_ERR_LENGTH] | length_err_i;
		link_err_nxt[`DMSR_ERR_PARITY] = link_err_nxt[`DMSR_ERR_PARITY] | parity_err_i;
		link_err_nxt[`DMSR_ERR_OVERRUN] = link_err_nxt[`DMSR_ERR_OVERRUN] | overrun_err_i;
		link_err_nxt[`DMSR_ERR_FRAMING] = link_err_nxt[`DMSR_ERR_FRAMING] | framing_err_i;
		link_err_nxt[`DMSR_ERR_TIMEOUT] = link_err_nxt[`DMSR_ERR_TIMEOUT] | timeout_err_i;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link_err_r <= `DMSR_WORD_RESET;
		end else begin
			link_err_r <= link_err_nxt & `DMSR_ERR_MASK;
		end
	end

	// address decode; unknown numbers answer bad address
	always_comb begin
		rd_word = `DMSR_WORD_RESET;
		addr_hit = 1'b1;
		case (req_addr_i)
			`DMSR_ADDR_INPUT_IMAGE: rd_word = input_image_r;
			`DMSR_ADDR_CONDITION: rd_word = condition_r;
			`DMSR_ADDR_OUTPUT_IMAGE: rd_word = output_image_r;
			`DMSR_ADDR_DC_LINK: rd_word = dc_link_voltage_i;
			`DMSR_ADDR_FEEDBACK: rd_word = feedback_level_i;
			`DMSR_ADDR_SIGNED_A: rd_word = signed_monitor_a_i;
			`DMSR_ADDR_SIGNED_B: rd_word = signed_monitor_b_i;
			`DMSR_ADDR_MAIN_FW: rd_word = main_firmware_version_i;
			`DMSR_ADDR_FLASH_FW: rd_word = flash_firmware_version_i;
			`DMSR_ADDR_LINK_ERR: rd_word = link_err_r;
			`DMSR_ADDR_POWER_RATING: rd_word = power_rating_setting_i;
			`DMSR_ADDR_CTRL_METHOD: rd_word = control_method_code_i;
			default: addr_hit = 1'b0;
		endcase
		if (!addr_hit) begin
			rd_status = DMSR_ACC_BAD_ADDR;
		end else if (req_write_i) begin
			rd_status = DMSR_ACC_READ_ONLY;
		end else begin
			rd_status = DMSR_ACC_OK;
		end
	end

	// answer one cycle after the request; refused accesses return zero data
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o <= `DMSR_WORD_RESET;
			rsp_status_o <= DMSR_ACC_OK;
		end else begin
			rsp_valid_o <= req_valid_i;
			if (req_valid_i) begin
				rsp_status_o <= rd_status;
				rsp_data_o <= (rd_status == DMSR_ACC_OK) ? rd_word : `DMSR_WORD_RESET;
			end
		end
	end
endmodule

// file: verif/dmsr_props.sv
// assertions on the access ports of the monitor bank
`timescale 1ns/1ps
module dmsr_props import dmsr_pkg::*; (
	input wire logic ref_clk_i, // clock
	input wire logic reset_n_i, // reset, active low
	input wire logic req_valid_i, // request strobe
	input wire logic req_write_i, // write request
	input wire dmsr_word_t req_addr_i, // register number
	input wire logic timeout_err_i, // time-out pulse
	input wire logic rsp_valid_o, // answer strobe
	input wire dmsr_word_t rsp_data_o, // answer data
	input wire dmsr_acc_t rsp_status_o // answer status
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// a read request, the cause of the spare-bit and time-out data checks below
	wire rd = req_valid_i && !req_write_i;
	a_answer_once: assert property (req_valid_i |=> rsp_valid_o) else $error("no answer");
	a_no_stray: assert property (!req_valid_i |=> !rsp_valid_o) else $error("stray answer");
	a_data_held: assert property (!req_valid_i |=> $stable(rsp_data_o)) else $error("data moved");
	a_write_refused: assert property (req_valid_i && req_write_i |=>
		rsp_status_o != DMSR_ACC_OK && rsp_data_o == 16'h0000) else $error("write taken");
	a_input_spare: assert property (rd && req_addr_i == 16'h002B |=> rsp_data_o[15:7] == 9'h000)
		else $error("input spare set");
	a_output_spare: assert property (rd && req_addr_i == 16'h002D |=> rsp_data_o[15:2] == 14'h0000)
		else $error("output spare set");
	a_link_spare: assert property (rd && req_addr_i == 16'h003D |=> rsp_data_o[15:7] == 9'h000 && !rsp_data_o[2])
		else $error("link spare set");
	// a read taken on the pulse edge still returns the old image, so look at a read one cycle later
	a_timeout_seen: assert property (timeout_err_i ##1 (rd && req_addr_i == 16'h003D) |=> rsp_data_o[6])
		else $error("time-out not latched");
	a_timeout_flags: assert property (timeout_err_i ##1 (rd && req_addr_i == 16'h002C) |=> rsp_data_o[15:14] == 2'b11)
		else $error("time-out flags clear");
	c_write: cover property (req_valid_i && req_write_i);
	c_err_read: cover property (timeout_err_i && rd);
	c_bad_addr: cover property (rsp_valid_o && rsp_status_o == DMSR_ACC_BAD_ADDR);
endmodule

// file: verif/dmsr_plc_master.sv
// bus master model issuing single-word register accesses
`timescale 1ns/1ps
module dmsr_plc_master import dmsr_pkg::*; (
	input wire logic ref_clk_i, // clock
	input wire dmsr_word_t rsp_data_o, // answer data
	input wire dmsr_acc_t rsp_status_o, // answer status
	output logic req_valid_i = 1'b0, // request strobe
	output logic req_write_i = 1'b0, // write request
	output dmsr_word_t req_addr_i = 16'h0000 // register number
);
	// writes go out only where a test asks for a refusal
	task automatic access(input logic w, input dmsr_word_t a, output dmsr_word_t d, output dmsr_acc_t s);
		@(posedge ref_clk_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_addr_i <= a;
		@(posedge ref_clk_i);
		// released lines show the inverse, so a stale value is never mistaken for a held one
		req_valid_i <= 1'b0;
		req_write_i <= ~w;
		req_addr_i <= ~a;
		// the answer stands for the one cycle after the taking edge
		@(posedge ref_clk_i);
		d = rsp_data_o;
		s = rsp_status_o;
	endtask
endmodule

// file: verif/drive_monitor_status_registers_test.sv
// self-checking bench for the drive monitor register bank
`timescale 1ns/1ps
module drive_monitor_status_registers_test;
	import dmsr_pkg::*;
	logic ref_clk_i = 1'b0, reset_n_i = 1'b0, running_i = 1'b0, zero_speed_i = 1'b0, freq_agree_i = 1'b0;
	logic desired_agree_i = 1'b0, startup_done_i = 1'b0, low_voltage_i = 1'b0, baseblock_i = 1'b0;
	logic overtorque_i = 1'b0, retrying_i = 1'b0, drive_fault_i = 1'b0, ref_from_link_i = 1'b0;
	logic run_from_link_i = 1'b0, error_reset_i = 1'b0, req_valid_i, req_write_i, rsp_valid_o;
	logic [6:0] input_terminal_i = 7'h00;
	logic [1:0] output_contact_i = 2'h0;
	logic [5:0] err = 6'h00;
	logic [15:0] output_freq_i = 16'h0064, detection_level_setting_i = 16'h0064;
	wire crc_err_i = err[0], length_err_i = err[1], parity_err_i = err[2];
	wire overrun_err_i = err[3], framing_err_i = err[4], timeout_err_i = err[5];
	dmsr_word_t dc_link_voltage_i = 16'hC031, feedback_level_i = 16'hC038, signed_monitor_a_i = 16'hC039;
	dmsr_word_t signed_monitor_b_i = 16'hC03A, main_firmware_version_i = 16'hC03B;
	dmsr_word_t flash_firmware_version_i = 16'hC03C, power_rating_setting_i = 16'hC03E;
	dmsr_word_t control_method_code_i = 16'hC03F, req_addr_i, rsp_data_o, d, m;
	dmsr_acc_t rsp_status_o, s;
	int n_fail = 0, checked = 0, cyc = 0;
	int pos[6] = '{0, 1, 3, 4, 5, 6};
	dmsr_word_t words[8] = '{16'h0031, 16'h0038, 16'h0039, 16'h003A, 16'h003B, 16'h003C, 16'h003E, 16'h003F};
	dmsr_monitor_bank dut(.*);
	dmsr_plc_master plc(.*);
	initial begin
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input string n, input dmsr_word_t e, input dmsr_word_t g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// one access, then data and status judged together
	task automatic rd(input dmsr_word_t a, input dmsr_word_t e, input dmsr_acc_t es = DMSR_ACC_OK, input logic w = 1'b0);
		plc.access(w, a, d, s);
		chk("data", e, d);
		chk("status", es, s);
	endtask
	task automatic set_st(input logic [11:0] v);
		{drive_fault_i, retrying_i, overtorque_i, run_from_link_i, ref_from_link_i, baseblock_i,
			low_voltage_i, startup_done_i, desired_agree_i, freq_agree_i, zero_speed_i, running_i} <= v;
	endtask
	// error pulse is sampled one edge before the edge that takes the read, since reads see the old image
	task automatic err_rd(input int k, input dmsr_word_t a);
		fork
			plc.access(1'b0, a, d, s);
			begin
				err[k] <= 1'b1;
				@(posedge ref_clk_i) err[k] <= 1'b0;
			end
		join
	endtask
	task automatic t_inputs;
		foreach (words[i]) rd(words[i], {8'hC0, words[i][7:0]});
		input_terminal_i <= 7'h55;
		repeat (3) @(posedge ref_clk_i);
		rd(16'h002B, 16'h0055);
		input_terminal_i <= 7'h2A;
		repeat (3) @(posedge ref_clk_i);
		rd(16'h002B, 16'h002A);
		output_contact_i <= 2'b10;
		rd(16'h002D, 16'h0002);
	endtask
	task automatic t_status;
		set_st(12'h355);
		rd(16'h002C, 16'h0B75);
		set_st(12'hCAA);
		output_freq_i <= 16'h0063;
		rd(16'h002C, 16'h649A);
	endtask
	task automatic t_errors;
		set_st(12'h355);
		m = 16'h0000;
		for (int k = 0; k < 6; k++) begin
			err_rd(k, 16'h003D);
			m = m | (16'h0001 << pos[k]);
			chk("link latch", m, d);
		end
		err_rd(5, 16'h002C);
		chk("error flags", 16'hC000, d & 16'hC000);
		@(posedge ref_clk_i) error_reset_i <= 1'b1;
		@(posedge ref_clk_i) error_reset_i <= 1'b0;
		rd(16'h003D, 16'h0000);
		rd(16'h002C, 16'h0B55);
	endtask
	task automatic t_refuse;
		rd(16'h002C, 16'h0000, DMSR_ACC_READ_ONLY, 1'b1);
		rd(16'h0040, 16'h0000, DMSR_ACC_BAD_ADDR);
		rd(16'h0000, 16'h0000, DMSR_ACC_BAD_ADDR, 1'b1);
	endtask
	task automatic conclude;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		t_inputs;
		t_status;
		t_errors;
		t_refuse;
		conclude;
	end
	// a hang is cut short well past the ninety or so cycles the run needs
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			conclude;
		end
	end
endmodule
bind dmsr_monitor_bank dmsr_props props_i(.*);
